// ### design/fcb_fuse_bytes.sv
/*
  Three configuration fuse bytes with a programmer port, and configuration
  latches that capture the fuses while the system reset is held.
  Assumes the programmer port is synchronous to clk_i and that
  sys_reset_i is the device's system reset level, high while in reset.
*/
// Functional notes
// - Three fuse bytes: extended, high, low.
// - Programmed fuse reads zero, unprogrammed one.
// - Extended bits 7..3 stage-controller reset fuses, default one.
// - Extended bits 2..0 brown-out level, default 101.
// - High 7 reset disable, 6 debug, 5 serial.
// - High bit 4 programmed forces watchdog on.
// - High bit 3 programmed keeps nonvolatile data.
// - High 2..1 boot size, bit 0 vector.
// - Low 7 divide by eight, 6 clock out.
// - Low bits 5..4 start-up time, default 10.
// - Low bits 3..0 clock source, default 0010.
// - Chip erase leaves fuses unchanged.
// - Lock bit one programmed blocks fuse changes.
// - Code 0010 selects internal 8 MHz oscillator.
module fcb_fuse_bytes
  import fcb_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sys_reset_i,
  // Programmer port.
  input  wire logic       prog_wr_i,
  input  wire logic       prog_erase_i,
  input  wire logic [1:0] prog_sel_i,
  input  wire logic [7:0] prog_wdata_i,
  input  wire logic       serial_mode_i,
  input  wire logic       chip_erase_i,
  input  wire logic       lock_bit_one_i,
  output logic [7:0]      prog_rdata_o,
  output logic            prog_refused_o,
  // Latched configuration.
  output logic            stage_ctl2_reset_behaviour_o,
  output logic            stage_ctl2_extra_out_reset_o,
  output logic            stage_ctl_reduced_reset_o,
  output logic            stage_out_reset_value_o,
  output logic            stage_in_reset_behaviour_o,
  output logic [2:0]      brownout_level_o,
  output logic            ext_reset_disable_o,
  output logic            debug_link_enable_o,
  output logic            serial_prog_enable_o,
  output logic            watchdog_forced_on_o,
  output logic            nvdata_keep_on_erase_o,
  output logic [1:0]      boot_size_o,
  output logic            reset_vector_select_o,
  output logic            clock_div_by_eight_o,
  output logic            clock_to_pin_o,
  output logic [1:0]      startup_time_o,
  output logic [3:0]      clock_source_o,
  output logic            clk_src_rc8m_o,
  output logic            pll_src_rc_o
);
  // ----------------------------------------------------------------------
  // Fuse storage.
  // ----------------------------------------------------------------------
  logic [7:0] fuse_val [FCB_NBYTES];
  logic [7:0] cell_mask [FCB_NBYTES];
  logic [7:0] cell_data;
  logic [FCB_NBYTES-1:0] cell_wr;
  logic       wr_ok;

  localparam logic [7:0] DEFAULTS [FCB_NBYTES] =
    '{FCB_EXT_DEFAULT, FCB_HIGH_DEFAULT, FCB_LOW_DEFAULT};

  // Write is refused under the lock; chip erase never reaches the cells.
  assign wr_ok = (prog_wr_i | prog_erase_i) & ~lock_bit_one_i
               & ~chip_erase_i
               & (prog_sel_i != 2'h3);
  // An erase command returns the selected byte to all ones except, in serial mode, the serial enable bit.
  assign cell_data = prog_erase_i ? 8'hFF : prog_wdata_i;
  assign prog_refused_o = (prog_wr_i | prog_erase_i) & ~wr_ok;

  genvar g;
  generate
    for (g = 0; g < FCB_NBYTES; g++) begin : g_cell
      always_comb begin
        cell_mask[g] = 8'hFF;
        // The serial enable bit is masked off while in serial mode.
        if (g == FCB_SEL_HIGH && serial_mode_i) begin
          cell_mask[g][HI_SERIAL_PROG_EN] = 1'b0;
        end
      end
      assign cell_wr[g] = wr_ok & (prog_sel_i == g);
      fcb_fuse_cell #(.DEFAULT(DEFAULTS[g])) u_cell (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_i      (cell_wr[g]),
        .wr_data_i (cell_data),
        .wr_mask_i (cell_mask[g]),
        .value_o   (fuse_val[g])
      );
    end
  endgenerate

  always_comb begin
    prog_rdata_o = 8'hFF;
    if (prog_sel_i != 2'h3) begin
      prog_rdata_o = fuse_val[prog_sel_i];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration latches: follow fuses in reset, hold afterwards.
  // ----------------------------------------------------------------------
  logic [7:0] ext_q, ext_d, hi_q, hi_d, lo_q, lo_d;

  always_comb begin
    ext_d = ext_q;
    hi_d  = hi_q;
    lo_d  = lo_q;
    if (sys_reset_i) begin
      ext_d = fuse_val[FCB_SEL_EXT];
      hi_d  = fuse_val[FCB_SEL_HIGH];
      lo_d  = fuse_val[FCB_SEL_LOW];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_q <= FCB_EXT_DEFAULT;
      hi_q  <= FCB_HIGH_DEFAULT;
      lo_q  <= FCB_LOW_DEFAULT;
    end else begin
      ext_q <= ext_d;
      hi_q  <= hi_d;
      lo_q  <= lo_d;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded configuration; enables are active when the fuse reads zero.
  // ----------------------------------------------------------------------
  assign stage_ctl2_reset_behaviour_o = ext_q[EXT_STAGE_CTL2_RB];
  assign stage_ctl2_extra_out_reset_o = ext_q[EXT_STAGE_CTL2_XOUT];
  assign stage_ctl_reduced_reset_o    = ext_q[EXT_STAGE_REDUCED];
  assign stage_out_reset_value_o      = ext_q[EXT_STAGE_OUT_VAL];
  assign stage_in_reset_behaviour_o   = ext_q[EXT_STAGE_IN_RB];
  assign brownout_level_o   = ext_q[EXT_BROWNOUT_MSB:0];
  assign ext_reset_disable_o =
    (hi_q[HI_EXT_RESET_DIS] == FCB_PROGRAMMED);
  assign debug_link_enable_o =
    (hi_q[HI_DEBUG_LINK_EN] == FCB_PROGRAMMED);
  assign serial_prog_enable_o =
    (hi_q[HI_SERIAL_PROG_EN] == FCB_PROGRAMMED);
  assign watchdog_forced_on_o =
    (hi_q[HI_WATCHDOG_ON] == FCB_PROGRAMMED);
  assign nvdata_keep_on_erase_o =
    (hi_q[HI_NVDATA_KEEP] == FCB_PROGRAMMED);
  assign boot_size_o = hi_q[HI_BOOT_SIZE_MSB:HI_BOOT_SIZE_LSB];
  assign reset_vector_select_o = hi_q[HI_RESET_VECTOR];
  assign clock_div_by_eight_o =
    (lo_q[LO_CLOCK_DIV8] == FCB_PROGRAMMED);
  assign clock_to_pin_o = (lo_q[LO_CLOCK_TO_PIN] == FCB_PROGRAMMED);
  assign startup_time_o = lo_q[LO_STARTUP_MSB:LO_STARTUP_LSB];
  assign clock_source_o = lo_q[LO_CLOCK_SRC_MSB:0];
  assign clk_src_rc8m_o = (clock_source_o == FCB_CLKSRC_RC8M);
  assign pll_src_rc_o   = clk_src_rc8m_o;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  property p_lock_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
    lock_bit_one_i |=> (fuse_val[0] == $past(fuse_val[0]))
      && (fuse_val[1] == $past(fuse_val[1]))
      && (fuse_val[2] == $past(fuse_val[2]));
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("Fuse changed while locked.");

  property p_erase_holds;
    @(posedge clk_i) disable iff (!rst_b_i)
    chip_erase_i |=> (fuse_val[0] == $past(fuse_val[0]))
      && (fuse_val[1] == $past(fuse_val[1]))
      && (fuse_val[2] == $past(fuse_val[2]));
  endproperty
  a_erase_holds: assert property (p_erase_holds)
    else $error("Chip erase altered a fuse.");

  property p_serial_bit;
    @(posedge clk_i) disable iff (!rst_b_i)
    serial_mode_i |=> (fuse_val[1][HI_SERIAL_PROG_EN]
      == $past(fuse_val[1][HI_SERIAL_PROG_EN]));
  endproperty
  a_serial_bit: assert property (p_serial_bit)
    else $error("Serial enable fuse changed in serial mode.");

  property p_write_lands;
    @(posedge clk_i) disable iff (!rst_b_i)
    (prog_wr_i && !lock_bit_one_i && !chip_erase_i
      && prog_sel_i == FCB_SEL_LOW)
    |=> (fuse_val[2] == $past(prog_wdata_i));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Permitted fuse write not stored.");

  sequence s_run;
    !sys_reset_i [*2];
  endsequence
  property p_latch_fixed;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_run |-> (clock_source_o == $past(clock_source_o));
  endproperty
  a_latch_fixed: assert property (p_latch_fixed)
    else $error("Configuration moved outside reset.");

  property p_latch_load;
    @(posedge clk_i) disable iff (!rst_b_i)
    sys_reset_i |=> (hi_q == $past(fuse_val[1]));
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("Latch did not follow fuses in reset.");

  property p_rc8m;
    @(posedge clk_i) disable iff (!rst_b_i)
    (sys_reset_i && fuse_val[FCB_SEL_LOW][LO_CLOCK_SRC_MSB:0]
      == FCB_CLKSRC_RC8M) |=> clk_src_rc8m_o && pll_src_rc_o;
  endproperty
  a_rc8m: assert property (p_rc8m)
    else $error("Code 0010 not decoded as internal oscillator.");

  property p_wdt;
    @(posedge clk_i) disable iff (!rst_b_i)
    sys_reset_i |=>
      (watchdog_forced_on_o != $past(fuse_val[1][HI_WATCHDOG_ON]));
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("Watchdog force polarity wrong.");
endmodule // fcb_fuse_bytes

// ### design/fcb_fuse_cell.sv
/*
  One non-volatile fuse byte. A write replaces only the bits set in the mask; the
  programmer's erase-fuse command is a write of all ones, so it also sets only the masked bits.
  Assumes the owner gates every write with the lock and mode checks.
*/
module fcb_fuse_cell
  import fcb_pkg::*;
#(
  parameter logic [7:0] DEFAULT = 8'hFF
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Write port.
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [7:0] wr_mask_i,
  // Stored value.
  output logic [7:0]      value_o
);
  logic [7:0] val_q;
  logic [7:0] val_d;

  // Non-volatile contents survive reset; the asynchronous reset value only
  // models the part as delivered on first power-up of the simulation.
  always_comb begin
    val_d = val_q;
    if (wr_i) begin
      val_d = (val_q & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      val_q <= DEFAULT;
    end else begin
      val_q <= val_d;
    end
  end

  assign value_o = val_q;
endmodule // fcb_fuse_cell

// ### design/fcb_pkg.sv
/*
  Constants for the configuration fuse block: byte layout, bit positions,
  reset (delivery) values and the clock-source code.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcb_pkg;
  // ----------------------------------------------------------------------
  // Layout.
  // ----------------------------------------------------------------------
  localparam int unsigned FCB_NBYTES = 3;
  localparam logic [1:0]  FCB_SEL_EXT  = 2'h0;
  localparam logic [1:0]  FCB_SEL_HIGH = 2'h1;
  localparam logic [1:0]  FCB_SEL_LOW  = 2'h2;
  // Extended byte.
  localparam int unsigned EXT_STAGE_CTL2_RB   = 7;
  localparam int unsigned EXT_STAGE_CTL2_XOUT = 6;
  localparam int unsigned EXT_STAGE_REDUCED   = 5;
  localparam int unsigned EXT_STAGE_OUT_VAL   = 4;
  localparam int unsigned EXT_STAGE_IN_RB     = 3;
  localparam int unsigned EXT_BROWNOUT_MSB    = 2;
  // High byte.
  localparam int unsigned HI_EXT_RESET_DIS    = 7;
  localparam int unsigned HI_DEBUG_LINK_EN    = 6;
  localparam int unsigned HI_SERIAL_PROG_EN   = 5;
  localparam int unsigned HI_WATCHDOG_ON      = 4;
  localparam int unsigned HI_NVDATA_KEEP      = 3;
  localparam int unsigned HI_BOOT_SIZE_MSB    = 2;
  localparam int unsigned HI_BOOT_SIZE_LSB    = 1;
  localparam int unsigned HI_RESET_VECTOR     = 0;
  // Low byte.
  localparam int unsigned LO_CLOCK_DIV8       = 7;
  localparam int unsigned LO_CLOCK_TO_PIN     = 6;
  localparam int unsigned LO_STARTUP_MSB      = 5;
  localparam int unsigned LO_STARTUP_LSB      = 4;
  localparam int unsigned LO_CLOCK_SRC_MSB    = 3;
  // ----------------------------------------------------------------------
  // Default (delivery) values; a programmed fuse reads as zero.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FCB_EXT_DEFAULT  = 8'hFD;
  localparam logic [7:0]  FCB_HIGH_DEFAULT = 8'hD9;
  localparam logic [7:0]  FCB_LOW_DEFAULT  = 8'h62;
  localparam logic [3:0]  FCB_CLKSRC_RC8M  = 4'h2;
  localparam logic        FCB_PROGRAMMED   = 1'b0;
endpackage

// ### verif/fcb_prog_model.sv
/*
  Programmer model: drives the fuse block's programmer port.
  Assumes one bench process calls its tasks, on the clock of the block.
*/
module fcb_prog_model (
  // Clock.
  input  wire logic       clk_i,
  // Programmer port.
  output logic            wr_o,
  output logic            erase_o,
  output logic [1:0]      sel_o,
  output logic [7:0]      wdata_o,
  output logic            serial_o,
  output logic            chip_erase_o,
  output logic            lock_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       refused_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_o, erase_o, serial_o, chip_erase_o, lock_o} = 5'h00;
    sel_o   = 2'h3;
    wdata_o = 8'h00;
  end
  // Data is inverted after each request, so a stale value never matches.
  task automatic access(input logic er, input logic [1:0] s,
                        input logic [7:0] d, output logic rf);
    @(posedge clk_i);
    wr_o    <= ~er;
    erase_o <= er;
    sel_o   <= s;
    wdata_o <= d;
    @(negedge clk_i);
    rf = refused_i;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    erase_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic read(input logic [1:0] s, output logic [7:0] v);
    @(posedge clk_i);
    sel_o <= s;
    @(negedge clk_i);
    v = rdata_i;
  endtask
  // Lock is raised only after every fuse write is done.
  task automatic mode(input logic ser, input logic ce, input logic lk);
    @(posedge clk_i);
    serial_o     <= ser;
    chip_erase_o <= ce;
    lock_o       <= lk;
  endtask
endmodule // fcb_prog_model

// ### verif/test_fuse_configuration_bytes.sv
/*
  Self-checking bench for the fuse block with a programmer model.
  Assumes the latches load while sys_reset_i is high.
*/
module test_fuse_configuration_bytes import fcb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        sys_reset_i = 1'b0;
  logic        wr, er, ser, ce, lk, refused, rf;
  logic [1:0]  sel;
  logic [7:0]  wd, rd, v;
  wire logic [25:0] cfg;
  int          errors = 0;
  int          n_checks = 0;
  always #25 clk_i = ~clk_i;
  fcb_prog_model prog_u (.clk_i(clk_i), .wr_o(wr), .erase_o(er),
    .sel_o(sel), .wdata_o(wd), .serial_o(ser), .chip_erase_o(ce),
    .lock_o(lk), .rdata_i(rd), .refused_i(refused));
  fcb_fuse_bytes dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sys_reset_i(sys_reset_i), .prog_wr_i(wr), .prog_erase_i(er),
    .prog_sel_i(sel), .prog_wdata_i(wd), .serial_mode_i(ser),
    .chip_erase_i(ce), .lock_bit_one_i(lk), .prog_rdata_o(rd),
    .prog_refused_o(refused),
    .stage_ctl2_reset_behaviour_o(cfg[25]),
    .stage_ctl2_extra_out_reset_o(cfg[24]),
    .stage_ctl_reduced_reset_o(cfg[23]),
    .stage_out_reset_value_o(cfg[22]),
    .stage_in_reset_behaviour_o(cfg[21]),
    .brownout_level_o(cfg[20:18]), .ext_reset_disable_o(cfg[17]),
    .debug_link_enable_o(cfg[16]), .serial_prog_enable_o(cfg[15]),
    .watchdog_forced_on_o(cfg[14]), .nvdata_keep_on_erase_o(cfg[13]),
    .boot_size_o(cfg[12:11]), .reset_vector_select_o(cfg[10]),
    .clock_div_by_eight_o(cfg[9]), .clock_to_pin_o(cfg[8]),
    .startup_time_o(cfg[7:6]), .clock_source_o(cfg[5:2]),
    .clk_src_rc8m_o(cfg[1]), .pll_src_rc_o(cfg[0]));
  // Enables read one when the fuse bit is programmed, that is zero.
  function automatic logic [25:0] exp_cfg(logic [7:0] e, h, l);
    return {e, ~h[7:3], h[2:0], ~l[7:6], l[5:0], {2{l[3:0] == 4'h2}}};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic sys_pulse();
    @(posedge clk_i);
    sys_reset_i <= 1'b1;
    @(posedge clk_i);
    sys_reset_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic t_defaults();
    logic [7:0] exp [4] = '{8'hFD, 8'hD9, 8'h62, 8'hFF};
    sys_pulse();
    for (int i = 0; i < 4; i++) begin
      prog_u.read(2'(i), v);
      check("fuse byte", v, exp[i]);
    end
    check("cfg", cfg, exp_cfg(8'hFD, 8'hD9, 8'h62));
    $display("test defaults done");
  endtask
  task automatic t_write_latch();
    prog_u.access(1'b0, 2'h0, 8'h5A, rf);
    check("refused", rf, 1'b0);
    prog_u.access(1'b0, 2'h1, 8'h26, rf);
    prog_u.access(1'b0, 2'h2, 8'hA5, rf);
    prog_u.read(2'h2, v);
    check("low", v, 8'hA5);
    check("cfg held", cfg, exp_cfg(8'hFD, 8'hD9, 8'h62));
    sys_pulse();
    check("cfg", cfg, exp_cfg(8'h5A, 8'h26, 8'hA5));
    // High byte 26 programs bit 3, so the data must be kept on erase.
    check("keep on erase", cfg[13], 1'b1);
    $display("test write and latch done");
  endtask
  task automatic t_serial_erase();
    prog_u.access(1'b1, 2'h1, 8'h00, rf);
    prog_u.read(2'h1, v);
    check("erased", v, 8'hFF);
    prog_u.mode(1'b1, 1'b0, 1'b0);
    prog_u.access(1'b0, 2'h1, 8'h00, rf);
    prog_u.read(2'h1, v);
    check("serial keep", v, 8'h20);
    prog_u.mode(1'b0, 1'b0, 1'b0);
    prog_u.access(1'b0, 2'h3, 8'h00, rf);
    check("unmapped", rf, 1'b1);
    $display("test serial and erase done");
  endtask
  task automatic t_chip_erase();
    prog_u.mode(1'b0, 1'b1, 1'b0);
    prog_u.access(1'b0, 2'h2, 8'h00, rf);
    check("chip refused", rf, 1'b1);
    prog_u.mode(1'b0, 1'b0, 1'b0);
    prog_u.read(2'h2, v);
    check("low kept", v, 8'hA5);
    $display("test chip erase done");
  endtask
  task automatic t_lock();
    prog_u.mode(1'b0, 1'b0, 1'b1);
    prog_u.access(1'b0, 2'h0, 8'h00, rf);
    check("lock wr", rf, 1'b1);
    prog_u.access(1'b1, 2'h0, 8'h00, rf);
    check("lock er", rf, 1'b1);
    prog_u.read(2'h0, v);
    check("ext kept", v, 8'h5A);
    sys_pulse();
    check("cfg", cfg, exp_cfg(8'h5A, 8'h20, 8'hA5));
    $display("test lock done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_defaults();
    t_write_latch();
    t_serial_erase();
    t_chip_erase();
    t_lock();
    end_of_test();
  end
  // The run takes well under 200 cycles; ten times that means a hang.
  initial begin
    #(2000 * 50);
    errors++;
    end_of_test();
  end
endmodule // test_fuse_configuration_bytes
